// >>> common/ppct_pkg.sv
// Constants, register map and state types for the period capture timer.
// Assumes a single 100 MHz core clock and a plain strobe register port.
`default_nettype none
package ppct_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 16;
   localparam int PRE_W  = 5;
   localparam int EXT_N  = 3;
   localparam int FILT_LEN = 3;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CLKEN = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CTRL  = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_MODE  = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_IOCTL = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_CNT   = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQF  = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_IRQM  = 4'h6;

   // bit positions
   localparam int CLKEN_BIT   = 0;
   localparam int CR_START    = 0;
   localparam int CR_STATUS   = 1;
   localparam int CR_STOP     = 2;
   localparam int CR_EDGEF    = 4;
   localparam int CR_UNDF     = 5;
   localparam int IRQ_BIT     = 6;
   localparam int MR_MODE_LSB = 0;
   localparam int MR_SRC_LSB  = 4;
   localparam int IO_EDGSEL   = 0;
   localparam int IO_FILT_LSB = 4;

   // field codes
   localparam logic [2:0] MODE_PERIOD = 3'h4;
   localparam logic [2:0] SRC_CLK  = 3'h0;
   localparam logic [2:0] SRC_DIV8 = 3'h1;
   localparam logic [2:0] SRC_DIV2 = 3'h3;
   localparam logic [2:0] SRC_LOW  = 3'h4;
   localparam logic [2:0] SRC_EVT  = 3'h5;
   localparam logic [2:0] SRC_SUB  = 3'h6;
   localparam logic [1:0] FLT_NONE  = 2'h0;
   localparam logic [1:0] FLT_CLK   = 2'h1;
   localparam logic [1:0] FLT_DIV8  = 2'h2;
   localparam logic [1:0] FLT_DIV32 = 2'h3;
   localparam int EXT_LOW = 0;
   localparam int EXT_SUB = 1;
   localparam int EXT_EVT = 2;

   // prescaler taps: tick when masked bits are all ones
   localparam logic [PRE_W-1:0] DIV2_MASK  = 5'h01;
   localparam logic [PRE_W-1:0] DIV8_MASK  = 5'h07;
   localparam logic [PRE_W-1:0] DIV32_MASK = 5'h1F;

   // reset values and write masks
   localparam logic [CNT_W-1:0] CNT_RST  = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
   localparam logic [7:0] MODE_RST   = 8'h00;
   localparam logic [7:0] MODE_WMASK = 8'h7F;
   localparam logic [7:0] IOCTL_RST   = 8'h00;
   localparam logic [7:0] IOCTL_WMASK = 8'hF5;
   localparam logic MASK_RST = 1'b1;

   typedef enum logic [1:0] {
      CAP_IDLE,
      CAP_ARMED,
      CAP_RELOAD
   } ppct_cap_t;
endpackage
`default_nettype wire

// >>> verilog/ppct_input_filter.sv
// Capture pin conditioner: synchroniser plus three-sample digital filter.
// Assumes the prescaler count comes from the same core clock domain.
`default_nettype none
module ppct_input_filter
   import ppct_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic             holdClear,
   // pin and settings
   input  wire logic             pinIn,
   input  wire logic [1:0]       filterSel,
   input  wire logic [PRE_W-1:0] preCount,
   // conditioned level
   output logic                  level
);
   logic                sync1_q;
   logic                sync2_q;
   logic                sync3_q;
   logic                stable_q;
   logic [FILT_LEN-1:0] samp_q;
   logic                level_q;
   logic                strobe;

   assign level = level_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= pinIn;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // a change counts only once the last two stages agree
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stable_q <= 1'b0;
      end else if (sync2_q == sync3_q) begin
         stable_q <= sync3_q;
      end
   end

   always_comb begin
      case (filterSel)
         FLT_CLK:  strobe = 1'b1;
         FLT_DIV8: strobe = (preCount & DIV8_MASK) == DIV8_MASK;
         default:  strobe = (preCount & DIV32_MASK) == DIV32_MASK;
      endcase
   end

   // filtered level moves only after three equal samples, or at once when the filter is off
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         samp_q  <= '0;
         level_q <= 1'b0;
      end else if (holdClear) begin
         samp_q  <= '0;
         level_q <= 1'b0;
      end else if (filterSel == FLT_NONE) begin
         samp_q  <= {FILT_LEN{stable_q}};
         level_q <= stable_q;
      end else if (strobe) begin
         samp_q <= {samp_q[FILT_LEN-2:0], stable_q};
         if (&samp_q) begin
            level_q <= 1'b1;
         end else if (~|samp_q) begin
            level_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/ppct_timer.sv
// Period capture timer channel: down counter, capture and reload,
// edge and underflow flags, interrupt request and mask, supply gate.
// Assumes a strobe register port and asynchronous count-source pins.
`default_nettype none
module ppct_timer
   import ppct_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // register port
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWrData,
   input  wire logic              regWrEn,
   input  wire logic              regRdEn,
   output logic       [DATA_W-1:0] regRdData,
   // pins and external count sources
   input  wire logic              captureInputPin,
   input  wire logic              lowSpeedOsc,
   input  wire logic              subsystemClk,
   input  wire logic              eventLinkIn,
   // interrupt to the controller
   output logic                   timerInterrupt
);
   logic              clkEn_q;
   logic              startBit_q;
   logic              edgeFlag_q;
   logic              underFlag_q;
   logic [7:0]        modeReg_q;
   logic [7:0]        ioReg_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  reload_q;
   logic [CNT_W-1:0]  rdBuf_q;
   logic              bufHeld_q;
   logic              irqFlag_q;
   logic              maskBit_q;
   logic              timerInterrupt_q;
   logic [DATA_W-1:0] rdData_q;
   logic [PRE_W-1:0]  pre_q;
   logic              prevLvl_q;
   ppct_cap_t         capState_q;
   logic [EXT_N-1:0]  extRaw;
   logic [EXT_N-1:0]  ext1_q;
   logic [EXT_N-1:0]  ext2_q;
   logic [EXT_N-1:0]  ext3_q;
   logic [EXT_N-1:0]  extLvl_q;
   logic [EXT_N-1:0]  extRise_q;

   logic              timerRst;
   logic              timerWr;
   logic              ctrlWr;
   logic              cntWr;
   logic              stopReq;
   logic              running;
   logic              srcTick;
   logic              cntTick;
   logic              filtLvl;
   logic              edgeHit;
   logic              edgeSet;
   logic              undSet;
   logic              bufRead;
   logic [2:0]        srcSel;
   logic [2:0]        modeSel;
   logic [7:0]        ctrlRd;
   logic [DATA_W-1:0] rdData_d;

   assign regRdData      = rdData_q;
   assign timerInterrupt = timerInterrupt_q;

   ////////////////////////////////////////////////////////////////////////
   // decode and qualifiers

   assign timerRst = !clkEn_q;
   assign timerWr  = regWrEn && clkEn_q;
   assign ctrlWr   = timerWr && (regAddr == OFS_CTRL);
   assign cntWr    = timerWr && (regAddr == OFS_CNT);
   assign stopReq  = ctrlWr && regWrData[CR_STOP];
   assign bufRead  = regRdEn && clkEn_q && (regAddr == OFS_CNT);
   assign srcSel   = modeReg_q[MR_SRC_LSB +: 3];
   assign modeSel  = modeReg_q[MR_MODE_LSB +: 3];
   // other and prohibited mode codes leave the counter idle
   assign running  = clkEn_q && startBit_q
                     && (modeSel == MODE_PERIOD);
   assign cntTick  = running && srcTick;
   assign edgeSet  = cntTick && (capState_q == CAP_RELOAD);
   assign undSet   = cntTick && (capState_q != CAP_RELOAD)
                     && (cnt_q == CNT_ZERO);
   assign extRaw   = {eventLinkIn, subsystemClk, lowSpeedOsc};

   ////////////////////////////////////////////////////////////////////////
   // external count sources, each synchronised on the core clock

   genvar gi;
   generate
      for (gi = 0; gi < EXT_N; gi++) begin : g_ext
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               ext1_q[gi]    <= 1'b0;
               ext2_q[gi]    <= 1'b0;
               ext3_q[gi]    <= 1'b0;
               extLvl_q[gi]  <= 1'b0;
               extRise_q[gi] <= 1'b0;
            end else begin
               ext1_q[gi] <= extRaw[gi];
               ext2_q[gi] <= ext1_q[gi];
               ext3_q[gi] <= ext2_q[gi];
               if (ext2_q[gi] == ext3_q[gi]) begin
                  extLvl_q[gi] <= ext3_q[gi];
               end
               extRise_q[gi] <= (ext2_q[gi] == ext3_q[gi])
                                && ext3_q[gi] && !extLvl_q[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // prescaler and count-source select

   // free running so the divided ticks keep a steady phase
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pre_q <= '0;
      end else if (timerRst) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 5'h01;
      end
   end

   always_comb begin
      case (srcSel)
         SRC_CLK:  srcTick = 1'b1;
         SRC_DIV8: srcTick = (pre_q & DIV8_MASK) == DIV8_MASK;
         SRC_DIV2: srcTick = (pre_q & DIV2_MASK) == DIV2_MASK;
         SRC_LOW:  srcTick = extRise_q[EXT_LOW];
         SRC_EVT:  srcTick = extRise_q[EXT_EVT];
         SRC_SUB:  srcTick = extRise_q[EXT_SUB];
         default:  srcTick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // capture pin and active edge

   ppct_input_filter u_filter (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .holdClear (timerRst),
      .pinIn     (captureInputPin),
      .filterSel (ioReg_q[IO_FILT_LSB +: 2]),
      .preCount  (pre_q),
      .level     (filtLvl)
   );

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prevLvl_q <= 1'b0;
      end else begin
         prevLvl_q <= filtLvl;
      end
   end

   // 0 picks rising edges, 1 falling edges
   assign edgeHit = ioReg_q[IO_EDGSEL] ? (prevLvl_q && !filtLvl)
                                       : (!prevLvl_q && filtLvl);

   ////////////////////////////////////////////////////////////////////////
   // capture sequence: edge, capture tick, reload tick

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         capState_q <= CAP_IDLE;
      end else if (timerRst || stopReq || !running) begin
         capState_q <= CAP_IDLE;
      end else begin
         case (capState_q)
            CAP_IDLE: begin
               if (edgeHit) begin
                  capState_q <= CAP_ARMED;
               end
            end
            CAP_ARMED: begin
               if (cntTick) begin
                  capState_q <= CAP_RELOAD;
               end
            end
            default: begin
               if (cntTick) begin
                  capState_q <= CAP_IDLE;
               end
            end
         endcase
      end
   end

   // unread capture is kept; a later edge cannot overwrite it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdBuf_q   <= CNT_RST;
         bufHeld_q <= 1'b0;
      end else if (timerRst) begin
         rdBuf_q   <= CNT_RST;
         bufHeld_q <= 1'b0;
      end else if (capState_q == CAP_ARMED && cntTick
                   && !bufHeld_q) begin
         rdBuf_q   <= cnt_q;
         bufHeld_q <= 1'b1;
      end else if (bufRead) begin
         bufHeld_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter and reload value

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reload_q <= CNT_RST;
      end else if (timerRst) begin
         reload_q <= CNT_RST;
      end else if (cntWr) begin
         reload_q <= regWrData[CNT_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= CNT_RST;
      end else if (timerRst) begin
         cnt_q <= CNT_RST;
      end else if (stopReq) begin
         cnt_q <= reload_q;
      end else if (cntWr && !running) begin
         cnt_q <= regWrData[CNT_W-1:0];
      end else if (cntTick) begin
         if (edgeSet) begin
            cnt_q <= reload_q;
         end else if (cnt_q == CNT_ZERO) begin
            cnt_q <= reload_q;
         end else begin
            cnt_q <= cnt_q - CNT_ONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register: start bit and event flags

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         startBit_q <= 1'b0;
      end else if (timerRst) begin
         startBit_q <= 1'b0;
      end else if (ctrlWr) begin
         // forced stop overrides a start in the same write
         startBit_q <= regWrData[CR_START]
                       && !regWrData[CR_STOP];
      end
   end

   // a hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         edgeFlag_q  <= 1'b0;
         underFlag_q <= 1'b0;
      end else if (timerRst) begin
         edgeFlag_q  <= 1'b0;
         underFlag_q <= 1'b0;
      end else begin
         edgeFlag_q  <= edgeSet
                        || (edgeFlag_q
                            && !(ctrlWr && !regWrData[CR_EDGEF]));
         underFlag_q <= undSet
                        || (underFlag_q
                            && !(ctrlWr && !regWrData[CR_UNDF]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // supply gate, mode and i/o control

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         clkEn_q <= 1'b0;
      end else if (regWrEn && regAddr == OFS_CLKEN) begin
         clkEn_q <= regWrData[CLKEN_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         modeReg_q <= MODE_RST;
         ioReg_q   <= IOCTL_RST;
      end else if (timerRst) begin
         modeReg_q <= MODE_RST;
         ioReg_q   <= IOCTL_RST;
      end else if (timerWr && regAddr == OFS_MODE) begin
         modeReg_q <= regWrData[7:0] & MODE_WMASK;
      end else if (timerWr && regAddr == OFS_IOCTL) begin
         ioReg_q <= regWrData[7:0] & IOCTL_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt request flag, mask and output

   // flag and mask sit outside the timer, so the supply gate spares them
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irqFlag_q <= 1'b0;
      end else if (edgeSet || undSet) begin
         irqFlag_q <= 1'b1;
      end else if (regWrEn && regAddr == OFS_IRQF) begin
         irqFlag_q <= regWrData[IRQ_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         maskBit_q <= MASK_RST;
      end else if (regWrEn && regAddr == OFS_IRQM) begin
         maskBit_q <= regWrData[IRQ_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timerInterrupt_q <= 1'b0;
      end else begin
         timerInterrupt_q <= irqFlag_q && !maskBit_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path

   always_comb begin
      ctrlRd            = '0;
      ctrlRd[CR_START]  = startBit_q;
      ctrlRd[CR_STATUS] = running;
      ctrlRd[CR_EDGEF]  = edgeFlag_q;
      ctrlRd[CR_UNDF]   = underFlag_q;
      if (regAddr == OFS_CLKEN) begin
         rdData_d = DATA_W'(clkEn_q);
      end else if (regAddr == OFS_CTRL) begin
         rdData_d = DATA_W'(ctrlRd);
      end else if (regAddr == OFS_MODE) begin
         rdData_d = DATA_W'(modeReg_q);
      end else if (regAddr == OFS_IOCTL) begin
         rdData_d = DATA_W'(ioReg_q);
      end else if (regAddr == OFS_CNT) begin
         rdData_d = DATA_W'(rdBuf_q);
      end else if (regAddr == OFS_IRQF) begin
         rdData_d = DATA_W'({irqFlag_q, 6'h00});
      end else if (regAddr == OFS_IRQM) begin
         rdData_d = DATA_W'({maskBit_q, 6'h00});
      end else begin
         rdData_d = '0;
      end
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdData_q <= '0;
      end else if (regRdEn) begin
         rdData_q <= rdData_d;
      end else begin
         rdData_q <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   a_count_dec:
   assert property (@(posedge core_clk) disable iff (!resetn)
      (cntTick && !edgeSet && cnt_q != CNT_ZERO && !stopReq)
      |=> cnt_q == $past(cnt_q) - CNT_ONE)
      else $error("counter did not step down on tick");

   a_capture_val:
   assert property (@(posedge core_clk) disable iff (!resetn)
      (capState_q == CAP_ARMED && cntTick && !bufHeld_q)
      |=> rdBuf_q == $past(cnt_q)
          && (capState_q == CAP_RELOAD || !running))
      else $error("capture value or sequence wrong");

   a_reload_cnt:
   assert property (@(posedge core_clk) disable iff (!resetn)
      (edgeSet && !stopReq) |=> cnt_q == $past(reload_q))
      else $error("counter not reloaded after capture");

   a_edge_flag:
   assert property (@(posedge core_clk) disable iff (!resetn)
      edgeSet |=> edgeFlag_q && irqFlag_q)
      else $error("edge flag or request missing");

   a_buf_hold:
   assert property (@(posedge core_clk) disable iff (!resetn)
      (bufHeld_q && clkEn_q) |=> $stable(rdBuf_q))
      else $error("unread capture overwritten");

   a_underflow:
   assert property (@(posedge core_clk) disable iff (!resetn)
      undSet |=> underFlag_q && irqFlag_q && cnt_q == $past(reload_q))
      else $error("underflow not flagged or reloaded");

   a_supply_hold:
   assert property (@(posedge core_clk) disable iff (!resetn)
      !clkEn_q |=> !startBit_q && cnt_q == CNT_RST
                   && capState_q == CAP_IDLE)
      else $error("timer not held while supply is off");

   a_start_bit:
   assert property (@(posedge core_clk) disable iff (!resetn)
      ctrlWr |=> startBit_q
         == $past(regWrData[CR_START] && !regWrData[CR_STOP]))
      else $error("start bit not taken from write");

   a_irq_out:
   assert property (@(posedge core_clk) disable iff (!resetn)
      1'b1 |=> timerInterrupt_q == $past(irqFlag_q && !maskBit_q))
      else $error("interrupt output disagrees with flag and mask");

   a_flag_clear:
   assert property (@(posedge core_clk) disable iff (!resetn)
      (ctrlWr && !regWrData[CR_EDGEF] && !edgeSet) |=> !edgeFlag_q)
      else $error("edge flag not cleared by write of 0");
endmodule
`default_nettype wire

// >>> tb/ppct_pulse_source.sv
// Behavioural pulse source that drives the capture input pin.
// Assumes the bench gives high and low times in ns, off the clock grid.
`default_nettype none
module ppct_pulse_source (
   // control
   input  wire logic enable,
   input  var  int   highNs,
   input  var  int   lowNs,
   // pin
   output logic      pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle low while disabled, as a pulled-down line would be
   initial begin
      pin = 1'b0;
      forever begin
         wait (enable);
         #(lowNs) pin = 1'b1;
         #(highNs) pin = 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the period capture timer channel.
// Assumes a pulse source model on the capture pin, other sources idle.
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
   $display("BAD %s exp %h got %h", n, e, s); num_errors++; end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ppct_pkg::*;
   localparam logic [15:0] RLD = 16'h0100;
   logic              core_clk = 1'b0;
   logic              resetn = 1'b0;
   logic              regWrEn = 1'b0;
   logic              regRdEn = 1'b0;
   logic              pulseEn = 1'b0;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWrData = '0;
   logic [DATA_W-1:0] regRdData;
   logic [DATA_W-1:0] got;
   logic              captureInputPin;
   logic              timerInterrupt;
   int                highNs = 203;
   int                lowNs = 197;
   int                num_errors = 0;
   int                n_tests = 0;
   always #5 core_clk = ~core_clk;
   ppct_timer ppct_timer_i (.core_clk(core_clk), .resetn(resetn),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData),
      .captureInputPin(captureInputPin), .lowSpeedOsc(1'b0),
      .subsystemClk(1'b0), .eventLinkIn(1'b0),
      .timerInterrupt(timerInterrupt));
   ppct_pulse_source ppct_pulse_source_i (.enable(pulseEn),
      .highNs(highNs), .lowNs(lowNs), .pin(captureInputPin));
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge core_clk);
      regWrEn <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      #1 got = regRdData;
   endtask
   // skip two edges so a request being cleared cannot count
   task automatic wait_irq();
      repeat (2) @(posedge core_clk);
      // look mid-cycle, where the registered output has settled
      repeat (2000) begin
         @(negedge core_clk);
         if (timerInterrupt === 1'b1) break;
      end
      `CHK("irq", 1'b1, timerInterrupt)
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      num_errors++;
      results();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      rd(OFS_IRQM); `CHK("mask", 16'h0040, got)
      rd(OFS_IRQF); `CHK("flag", 16'h0000, got)
      wr(OFS_CTRL, 16'h0001);
      rd(OFS_CTRL); `CHK("ctrl off", 16'h0000, got)
      rd(OFS_CNT); `CHK("buf off", 16'hFFFF, got)
      rd(4'hF); `CHK("unmapped", 16'h0000, got)
      wr(OFS_CLKEN, 16'h0001);
      wr(OFS_MODE, {9'h000, SRC_CLK, 1'b0, MODE_PERIOD});
      rd(OFS_MODE); `CHK("mode", 16'h0004, got)
      wr(OFS_IOCTL, {10'h000, FLT_NONE, 4'h0});
      wr(OFS_CNT, RLD);
      wr(OFS_IRQF, 16'h0000);
      wr(OFS_IRQM, 16'h0000);
      wr(OFS_CTRL, 16'h0001);
      rd(OFS_CTRL); `CHK("run", 16'h0003, got & 16'h0003)
      pulseEn <= 1'b1;
      wait_irq();
      rd(OFS_CNT);
      wr(OFS_CTRL, 16'h0001);
      wr(OFS_IRQF, 16'h0000);
      wait_irq();
      rd(OFS_IRQF); `CHK("req", 16'h0040, got)
      rd(OFS_CTRL); `CHK("edge flag", 16'h0010, got & 16'h0030)
      // period change must not disturb the unread capture
      highNs = 303;
      lowNs = 297;
      repeat (200) @(posedge core_clk);
      rd(OFS_CNT); `CHK("held", RLD - 16'd38, got)
      wr(OFS_CTRL, 16'h0001);
      wr(OFS_IRQF, 16'h0000);
      wait_irq();
      rd(OFS_CNT); `CHK("period", RLD - 16'd58, got)
      // falling edges through the per-clock filter, same period
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_IOCTL, {10'h000, FLT_CLK, 4'h1});
      wr(OFS_IRQF, 16'h0000);
      wr(OFS_CTRL, 16'h0001);
      wait_irq();
      rd(OFS_CNT);
      wr(OFS_IRQF, 16'h0000);
      wait_irq();
      rd(OFS_CNT); `CHK("falling", RLD - 16'd58, got)
      wr(OFS_IRQM, 16'h0040);
      wr(OFS_IRQF, 16'h0040);
      repeat (3) @(negedge core_clk);
      `CHK("masked", 1'b0, timerInterrupt)
      pulseEn <= 1'b0;
      // divide-by-8 source: 33 ticks to underflow take 264 clocks
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_MODE, {9'h000, SRC_DIV8, 1'b0, MODE_PERIOD});
      wr(OFS_CNT, 16'h0020);
      wr(OFS_CTRL, 16'h0001);
      repeat (100) @(posedge core_clk);
      rd(OFS_CTRL); `CHK("slow", 16'h0003, got & 16'h0023)
      repeat (400) @(posedge core_clk);
      rd(OFS_CTRL); `CHK("underflow", 16'h0023, got & 16'h0023)
      // stopped, so no new underflow can race the flag checks
      wr(OFS_CTRL, 16'h0030);
      rd(OFS_CTRL); `CHK("keep", 16'h0020, got & 16'h0021)
      wr(OFS_CTRL, 16'h0000);
      rd(OFS_CTRL); `CHK("clear", 16'h0000, got & 16'h0031)
      wr(OFS_CLKEN, 16'h0000);
      rd(OFS_CNT); `CHK("gated", 16'hFFFF, got)
      results();
   end
endmodule
`default_nettype wire
